// [bench/cctm_ssi_model.sv]
// Purpose: far side, serial shift unit data and external count source
// Assumes: one clock domain
// Notes: a bit lasts 8 clocks, the count input rises every 4 clocks
`timescale 1ns/1ps
`default_nettype none
module cctm_ssi_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link
  output logic serial_data_in,
  output logic external_count_in,
  output logic bit_last
);
  logic [7:0] pat_r;
  logic [2:0] cnt_r;
  // ======
  // rotating bit pattern
  assign serial_data_in = pat_r[7];
  assign external_count_in = cnt_r[1];
  assign bit_last = (cnt_r == 3'h7);
  always_ff @(posedge clk) begin
    if (reset) begin
      pat_r <= 8'hb2;
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      if (bit_last) begin
        pat_r <= {pat_r[6:0], pat_r[7]};
      end
    end
  end
endmodule
`default_nettype wire

// [bench/cctm_timer_monitor.sv]
// Purpose: port checks of the compare timer
// Assumes: run, mask and mode bits are tracked from apb writes
// Notes: bound into every cctm_timer
`timescale 1ns/1ps
`default_nettype none
module cctm_timer_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // link
  input wire logic external_count_in,
  input wire logic serial_data_in,
  input wire logic timer_out_pin,
  input wire logic stage_clock_out,
  input wire logic timer_irq_req
);
  // ======
  // write tracking
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire bad = (paddr[7:6] != 2'h0) || (paddr[5:2] > 4'h6);
  wire wr_oms = wr && (paddr[7:2] == 6'h02);
  logic run_r, im_r;
  logic [1:0] tg_r, stop_r, mute_r, on_r;
  logic [2:0] om_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      run_r <= 1'b0;
      im_r <= 1'b0;
      tg_r <= 2'h0;
      om_r <= 3'h7;
      stop_r <= 2'h0;
      mute_r <= 2'h0;
      on_r <= 2'h0;
    end else begin
      if (wr && paddr[7:2] == 6'h00) begin
        run_r <= pwdata[0];
      end
      if (wr && paddr[7:2] == 6'h03) begin
        im_r <= pwdata[0];
        tg_r <= pwdata[3:2];
      end
      if (wr_oms && pwdata[2:0] != 3'h0) begin
        om_r <= pwdata[2:0];
      end
      stop_r <= run_r ? 2'h0 : stop_r + 2'(stop_r != 2'h3);
      mute_r <= im_r ? 2'h0 : mute_r + 2'(mute_r != 2'h3);
      on_r <= !run_r ? 2'h0 : on_r + 2'(on_r != 2'h3);
    end
  end
  // ======
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_decode_a: assert property (acc |-> pslverr == bad)
    else $error("pslverr wrong");
  read_zero_a: assert property (
    acc && !pwrite && (bad || paddr[5:3] == 3'h2) |-> prdata == 32'h0)
    else $error("read data not zero");
  reset_idle_a: assert property (disable iff (1'b0)
    reset |=> !timer_irq_req && !timer_out_pin && !stage_clock_out)
    else $error("outputs busy after reset");
  stop_quiet_a: assert property (
    stop_r == 2'h3 |-> !timer_irq_req && !stage_clock_out)
    else $error("activity while stopped");
  irq_mask_a: assert property (mute_r == 2'h3 |-> !timer_irq_req)
    else $error("masked irq seen");
  preset_pin_a: assert property (
    wr_oms && !run_r && pwdata[2:0] == 3'h7
    |-> ##2 timer_out_pin == $past(pwdata[3], 2))
    else $error("preset not on pin");
  preset_hold_a: assert property (
    wr_oms && on_r[1] && tg_r == 2'h0 && om_r == 3'h7
    && pwdata[2:0] == 3'h7 |-> ##1 $stable(timer_out_pin)[*2])
    else $error("preset applied while running");
  irq_seen_c: cover property (timer_irq_req);
  err_seen_c: cover property (acc && pslverr);
  run_preset_c: cover property (wr_oms && run_r);
endmodule
bind cctm_timer cctm_timer_monitor u_cctm_timer_monitor (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .external_count_in(external_count_in), .serial_data_in(serial_data_in),
  .timer_out_pin(timer_out_pin), .stage_clock_out(stage_clock_out),
  .timer_irq_req(timer_irq_req));
`default_nettype wire

// [bench/testbench.sv]
// Purpose: self-checking bench of the compare timer
// Assumes: apb slave answers in the access cycle
// Notes: rows set a mode and measure the irq period
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // row: mode, masks, low cmp, high cmp, ctrl, irq period
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] cam;
    logic [3:0] lo;
    logic [7:0] hi;
    logic [3:0] ctl;
    logic [11:0] per;
  } cctm_row_t;
  cctm_row_t rows [12] = '{
    36'hd3_0_02_1_003, 36'hd3_0_00_1_001, 36'hd3_0_ff_1_100,
    36'hc3_2_02_1_003, 36'he3_2_02_1_009, 36'ha3_2_02_1_012,
    36'h63_2_02_1_01b, 36'h23_2_02_1_024, 36'he3_0_02_1_003,
    36'hf3_2_01_1_013, 36'hd3_0_02_3_00c, 36'hd9_0_05_1_100};
  logic clk, reset, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, ext_in, ser, pin, sclk, irq, bit_last;
  int num_errors, compares, p;
  cctm_timer u_cctm_timer (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_in(ext_in),
    .serial_data_in(ser), .timer_out_pin(pin), .stage_clock_out(sclk),
    .timer_irq_req(irq));
  cctm_ssi_model u_cctm_ssi_model (
    .clk(clk), .reset(reset), .serial_data_in(ser),
    .external_count_in(ext_in), .bit_last(bit_last));
  // ======
  // tasks
  task automatic check(input logic [31:0] got, exp, input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e,
                       input logic x);
    apb(1'b0, a, 32'h0);
    check(rd & m, e, "read data");
    check(32'(err), 32'(x), "slave error");
  endtask
  task automatic setup(input logic [3:0] m, c, l, input logic [7:0] h,
                       input logic [3:0] r);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'(m));
    wr(8'h10, 32'(l));
    wr(8'h14, 32'(h));
    wr(8'h0c, 32'(c));
    wr(8'h00, 32'(r));
  endtask
  // cycles between two irq pulses or two pin changes
  task automatic gap(input logic tg, output int n);
    logic last;
    last = pin;
    n = 0;
    repeat (2) begin
      n = 1;
      @(negedge clk);
      while ((tg ? pin === last : irq !== 1'b1) && n < 2000) begin
        n++;
        @(negedge clk);
      end
      last = pin;
    end
  endtask
  task automatic quiet();
    int n;
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += int'(irq === 1'b1);
    end
    check(32'(n), 32'h0, "irq count");
  endtask
  task automatic pin_chk(input logic v);
    repeat (3) @(negedge clk);
    check(32'(pin), 32'(v), "pin level");
  endtask
  task automatic ser_chk(input logic g);
    repeat (3) @(negedge clk);
    repeat (8) begin
      do @(negedge clk); while (bit_last !== 1'b1);
      check(32'(g ? pin & ~ser : pin), 32'(g ? 1'b0 : ser), "pin data");
    end
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ======
  // clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever begin
      #4 clk = ~clk;
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    compares = 0;
    do_reset();
    foreach (rows[i]) begin
      setup(rows[i].cmd, rows[i].cam, rows[i].lo, rows[i].hi, rows[i].ctl);
      gap(1'b0, p);
      check(32'(p), 32'(rows[i].per), "irq period");
    end
    setup(4'hd, 4'h6, 4'h0, 8'h03, 4'h1);
    gap(1'b1, p);
    check(32'(p), 32'h4, "toggle period");
    wr(8'h0c, 32'h2);
    quiet();
    wr(8'h0c, 32'hb);
    quiet();
    // pin alternate function taken as enabled
    wr(8'h08, 32'h2);
    ser_chk(1'b0);
    wr(8'h08, 32'h5);
    ser_chk(1'b1);
    wr(8'h08, 32'h3);
    repeat (3) @(negedge clk);
    do @(negedge clk); while (bit_last !== 1'b1);
    p = int'(pin);
    @(negedge clk);
    check(32'(pin ^ p[0]), 32'h1, "manchester half bit");
    do_reset();
    // register reset values, access and decode
    rdchk(8'h00, '1, 32'h0, 1'b0);
    rdchk(8'h04, '1, 32'hf, 1'b0);
    rdchk(8'h08, 32'h7, 32'h7, 1'b0);
    rdchk(8'h0c, '1, 32'h0, 1'b0);
    rdchk(8'h10, '1, 32'h0, 1'b0);
    rdchk(8'h1c, '1, 32'h0, 1'b1);
    rdchk(8'h44, '1, 32'h0, 1'b1);
    wr(8'h0c, 32'ha);
    rdchk(8'h0c, '1, 32'ha, 1'b0);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h0);
    rdchk(8'h08, 32'h7, 32'h7, 1'b0);
    wr(8'h08, 32'h7);
    pin_chk(1'b0);
    wr(8'h08, 32'hf);
    pin_chk(1'b1);
    rdchk(8'h18, 32'h2001, 32'h2001, 1'b0);
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h7);
    pin_chk(1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire

// [hw/cctm_pkg.sv]
// Purpose: types of the compare timer and modulator
// Assumes: constants live in cctm_regs.svh
// Notes: enum codes equal the register field codes
package cctm_pkg;

  // ========================================================
  // counter modes
  typedef enum logic [1:0] {
    CM_CHAIN12 = 2'b11,
    CM_PRESC_DCG = 2'b10,
    CM_RUN_PRE = 2'b01,
    CM_STOP_PRE = 2'b00
  } cctm_cmode_t;

  // ========================================================
  // output modes
  typedef enum logic [2:0] {
    OM_TOGGLE = 3'b111,
    OM_BURST_FF = 3'b110,
    OM_BURST_SO = 3'b101,
    OM_BIPHASE = 3'b100,
    OM_MANCH = 3'b011,
    OM_DIRECT = 3'b010,
    OM_PWM = 3'b001,
    OM_NONE = 3'b000
  } cctm_omode_t;

  // ========================================================
  // software settings
  typedef struct packed {
    logic [1:0] duty;
    cctm_cmode_t cmode;
    logic preset;
    cctm_omode_t omode;
    logic otm;
    logic ctm;
    logic rm;
    logic im;
    logic [3:0] lo_cmp;
    logic [7:0] hi_cmp;
    logic run;
    logic ext_sel;
    logic tog_start;
  } cctm_cfg_t;

endpackage

// [hw/cctm_regs.svh]
// Purpose: register indices, fields and reset values of the timer
// Assumes: byte address is four times the register index
// Notes: definitions only
`ifndef CCTM_REGS_SVH
`define CCTM_REGS_SVH

// ==========================================================
// register indices
`define CCTM_IDX_CTRL 4'h0
`define CCTM_IDX_CMD 4'h1
`define CCTM_IDX_OMS 4'h2
`define CCTM_IDX_CAM 4'h3
`define CCTM_IDX_LCV 4'h4
`define CCTM_IDX_HCV 4'h5
`define CCTM_IDX_STAT 4'h6

// ==========================================================
// field positions
`define CCTM_CTRL_RUN 0
`define CCTM_CTRL_EXT 1
`define CCTM_CTRL_TST 2
`define CCTM_OMS_PRESET 3
`define CCTM_CAM_OTM 3
`define CCTM_CAM_CTM 2
`define CCTM_CAM_RM 1
`define CCTM_CAM_IM 0

// ==========================================================
// reset values
`define CCTM_RST_CTRL 3'h0
`define CCTM_RST_CMD 4'hf
`define CCTM_RST_OMS 4'hf
`define CCTM_RST_CAM 4'h0
`define CCTM_RST_LCV 4'hf
`define CCTM_RST_HCV 8'hff

`endif

// [hw/cctm_timer.sv]
// Purpose: cascadable 4-bit plus 8-bit compare timer with modulator
// Assumes: APB slave, zero wait states, inputs synchronous to clk
// Notes: counts on clk or on rising edges of external_count_in
// Function
// - duty field 11/10/01/00 divides by 1/2/3/4.
// - mode 11 chains stages to 12 bits, clock out on low overflow.
// - mode 10 runs 8-bit stage behind prescaler and duty generator.
// - mode 01 clocks 8-bit stage directly, prescaler runs, restarts.
// - mode 00 clocks 8-bit stage directly, prescaler held reset.
// - duty generator gives 25, 33 or 50 percent high time.
// - a write of output mode register while stopped presets the output flop.
// - preset is ignored while the timer runs.
// - select 111 toggles, 110 and 101 gate the duty output.
// - select 100 biphase, 011 Manchester encode serial data.
// - select 010 passes serial data, 001 is PWM, 000 forbidden.
// - 12-bit mode compares low nibble and high byte together.
// - other modes compare each stage with its own register.
// - match raises interrupt, toggles output or clocks next stage.
// - overflow toggle mask lets overflow toggle the output.
// - compare toggle mask lets a match toggle the output.
// - reset mask lets a match clear the counter.
// - interrupt mask gates the interrupt request.
// - interrupt source is match or overflow per masks and mode.
// - low compare zero passes the prescaler clock undivided.
// - run bit clear stops and resets, set lets counting run.
// - compare value y gives a period of y plus one clocks.
// - PWM toggles only on first match of each overflow period.
`include "cctm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cctm_timer
  import cctm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  input wire logic external_count_in,
  input wire logic serial_data_in,
  output logic timer_out_pin,
  output logic stage_clock_out,
  output logic timer_irq_req
);

  // ========================================================
  // state
  localparam cctm_cfg_t CFG_RST = '{
    duty: 2'(`CCTM_RST_CMD >> 2),
    cmode: cctm_cmode_t'(2'(`CCTM_RST_CMD)),
    preset: 1'(`CCTM_RST_OMS >> 3),
    omode: cctm_omode_t'(3'(`CCTM_RST_OMS)),
    otm: 1'(`CCTM_RST_CAM >> 3),
    ctm: 1'(`CCTM_RST_CAM >> 2),
    rm: 1'(`CCTM_RST_CAM >> 1),
    im: 1'(`CCTM_RST_CAM),
    lo_cmp: `CCTM_RST_LCV,
    hi_cmp: `CCTM_RST_HCV,
    run: 1'(`CCTM_RST_CTRL),
    ext_sel: 1'(`CCTM_RST_CTRL >> 1),
    tog_start: 1'(`CCTM_RST_CTRL >> 2)
  };

  cctm_cfg_t cfg_r;
  cctm_cfg_t cfg_nxt;
  logic [31:0] prdata_r;
  logic [31:0] rd_val;
  logic [3:0] lo_cnt_r;
  logic [3:0] lo_cnt_nxt;
  logic [7:0] hi_cnt_r;
  logic [7:0] hi_cnt_nxt;
  logic [1:0] dcg_cnt_r;
  logic [1:0] dcg_cnt_nxt;
  logic out_ff_r;
  logic out_ff_nxt;
  logic armed_r;
  logic armed_nxt;
  logic ext_prev_r;
  logic run_prev_r;
  logic half_r;
  logic bip_r;
  logic bip_nxt;
  logic pin_r;
  logic pin_nxt;
  logic clk_out_r;
  logic irq_r;

  // ========================================================
  // functions
  function automatic logic [3:0] inc4(input logic [3:0] v);
    inc4 = v + 4'h1;
  endfunction

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01;
  endfunction

  // ========================================================
  // bus decode
  wire [3:0] idx = paddr[5:2];
  wire addr_ok = (paddr[7:6] == 2'h0) && (idx <= `CCTM_IDX_STAT);
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite & addr_ok;
  wire wr_cmd = wr && (idx == `CCTM_IDX_CMD);
  wire wr_oms = wr && (idx == `CCTM_IDX_OMS);
  wire [2:0] wr_omode = pwdata[2:0];

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_r;

  always_comb begin
    cfg_nxt = cfg_r;
    if (wr) begin
      case (idx)
        `CCTM_IDX_CTRL: begin
          cfg_nxt.run = pwdata[`CCTM_CTRL_RUN];
          cfg_nxt.ext_sel = pwdata[`CCTM_CTRL_EXT];
          cfg_nxt.tog_start = pwdata[`CCTM_CTRL_TST];
        end
        `CCTM_IDX_CMD: begin
          cfg_nxt.duty = pwdata[3:2];
          cfg_nxt.cmode = cctm_cmode_t'(pwdata[1:0]);
        end
        `CCTM_IDX_OMS: begin
          cfg_nxt.preset = pwdata[`CCTM_OMS_PRESET];
          if (wr_omode != OM_NONE) begin
            cfg_nxt.omode = cctm_omode_t'(wr_omode);
          end
        end
        `CCTM_IDX_CAM: begin
          cfg_nxt.otm = pwdata[`CCTM_CAM_OTM];
          cfg_nxt.ctm = pwdata[`CCTM_CAM_CTM];
          cfg_nxt.rm = pwdata[`CCTM_CAM_RM];
          cfg_nxt.im = pwdata[`CCTM_CAM_IM];
        end
        `CCTM_IDX_LCV: begin
          cfg_nxt.lo_cmp = pwdata[3:0];
        end
        `CCTM_IDX_HCV: begin
          cfg_nxt.hi_cmp = pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rd_val = 32'h0;
    case (idx)
      `CCTM_IDX_CTRL: begin
        rd_val[2:0] = {cfg_r.tog_start, cfg_r.ext_sel, cfg_r.run};
      end
      `CCTM_IDX_CMD: begin
        rd_val[3:0] = {cfg_r.duty, cfg_r.cmode};
      end
      `CCTM_IDX_OMS: begin
        rd_val[3:0] = {cfg_r.preset, cfg_r.omode};
      end
      `CCTM_IDX_CAM: begin
        rd_val[3:0] = {cfg_r.otm, cfg_r.ctm, cfg_r.rm, cfg_r.im};
      end
      `CCTM_IDX_STAT: begin
        rd_val[13:0] = {pin_r, hi_cnt_r, lo_cnt_r, out_ff_r};
      end
      default: begin
        rd_val = 32'h0;
      end
    endcase
  end

  // ========================================================
  // count clock
  wire run = cfg_r.run;
  wire mode12 = cfg_r.cmode == CM_CHAIN12;
  wire mode_dcg = cfg_r.cmode == CM_PRESC_DCG;
  wire mode_direct = ~cfg_r.cmode[1];
  wire ext_rise = external_count_in & ~ext_prev_r;
  // external source only when 8-bit stage is direct
  wire ext_ok = mode_direct & cfg_r.ext_sel;
  wire tick = run & (ext_ok ? ext_rise : 1'b1);

  // ========================================================
  // low stage
  // prescaler stopped in mode 00
  wire lo_run = cfg_r.cmode != CM_STOP_PRE;
  wire lo_hit = lo_cnt_r == cfg_r.lo_cmp;
  wire lo_pulse = tick & lo_run & ~mode12 & lo_hit;
  wire lo_ovf = tick & mode12 & (lo_cnt_r == 4'hf);

  // ========================================================
  // duty cycle generator
  // last count is the inverted duty code
  wire [1:0] dcg_last = ~cfg_r.duty;
  wire dcg_bypass = mode12 | (cfg_r.duty == 2'b11);
  wire dcg_wrap = dcg_cnt_r == dcg_last;
  wire dcg_pulse = lo_pulse & (dcg_bypass | dcg_wrap);

  always_comb begin
    dcg_cnt_nxt = dcg_cnt_r;
    if (~run | dcg_bypass) begin
      dcg_cnt_nxt = 2'h0;
    end else if (lo_pulse) begin
      dcg_cnt_nxt = dcg_wrap ? 2'h0 : dcg_cnt_r + 2'h1;
    end
  end

  // high for one of 2, 3 or 4 prescaler periods
  wire dcg_level = dcg_bypass ? clk_out_r : (dcg_cnt_r == 2'h0);

  // ========================================================
  // high stage and compare
  logic hi_tick;
  always_comb begin
    unique case (cfg_r.cmode)
      CM_CHAIN12: hi_tick = lo_ovf;
      // fed by prescaler through duty generator
      CM_PRESC_DCG: hi_tick = dcg_pulse;
      CM_RUN_PRE: hi_tick = tick;
      CM_STOP_PRE: hi_tick = tick;
    endcase
  end

  wire [11:0] cnt12 = {hi_cnt_r, lo_cnt_r};
  // low nibble and high byte form one value
  wire [11:0] cmp12 = {cfg_r.hi_cmp, cfg_r.lo_cmp};
  wire m12 = tick & (cnt12 == cmp12);
  wire o12 = lo_ovf & (hi_cnt_r == 8'hff);
  // separate compare of the 8-bit stage
  wire m8 = hi_tick & (hi_cnt_r == cfg_r.hi_cmp);
  wire o8 = hi_tick & (hi_cnt_r == 8'hff);
  // one match signal drives every action
  wire high_stage_match = mode12 ? m12 : m8;
  wire high_stage_overflow = mode12 ? o12 : o8;
  wire match_clr = high_stage_match & cfg_r.rm;

  always_comb begin
    lo_cnt_nxt = lo_cnt_r;
    if (~run | ~lo_run | wr_cmd) begin
      lo_cnt_nxt = 4'h0;
    end else if (mode12) begin
      if (match_clr) begin
        lo_cnt_nxt = 4'h0;
      end else if (tick) begin
        lo_cnt_nxt = inc4(lo_cnt_r);
      end
    // prescaler period is compare plus one
    end else if (tick) begin
      lo_cnt_nxt = lo_hit ? 4'h0 : inc4(lo_cnt_r);
    end
  end

  always_comb begin
    hi_cnt_nxt = hi_cnt_r;
    if (~run) begin
      hi_cnt_nxt = 8'h00;
    // cleared after value y, period y plus one
    end else if (match_clr) begin
      hi_cnt_nxt = 8'h00;
    end else if (hi_tick) begin
      hi_cnt_nxt = inc8(hi_cnt_r);
    end
  end

  // ========================================================
  // output flip-flop
  wire pwm = cfg_r.omode == OM_PWM;
  // compare toggle, first match only in PWM
  wire cm_tog = cfg_r.ctm & high_stage_match & (~pwm | armed_r);
  wire of_tog = cfg_r.otm & high_stage_overflow;
  wire st_tog = cfg_r.tog_start & run & ~run_prev_r;
  wire preset_wr = wr_oms & ~run;

  always_comb begin
    out_ff_nxt = out_ff_r;
    if (preset_wr) begin
      out_ff_nxt = pwdata[`CCTM_OMS_PRESET];
    end else if (cm_tog | of_tog | st_tog) begin
      out_ff_nxt = ~out_ff_r;
    end
  end

  always_comb begin
    armed_nxt = armed_r;
    if (~run | high_stage_overflow) begin
      armed_nxt = 1'b1;
    end else if (pwm & high_stage_match) begin
      armed_nxt = 1'b0;
    end
  end

  // ========================================================
  // interrupt request
  logic irq_src;
  always_comb begin
    // mode 001 with compare toggle uses match only
    if (pwm & cfg_r.ctm) begin
      irq_src = high_stage_match;
    end else if (cfg_r.otm) begin
      irq_src = high_stage_overflow;
    end else begin
      irq_src = high_stage_match;
    end
  end

  // ========================================================
  // modulator
  wire stage_pulse = mode12 ? lo_ovf : lo_pulse;
  wire so = serial_data_in;

  always_comb begin
    bip_nxt = bip_r;
    // biphase flips at bit edge, mid-bit for zero
    if (stage_pulse & (half_r | ~so)) begin
      bip_nxt = ~bip_r;
    end
  end

  always_comb begin
    unique case (cfg_r.omode)
      OM_TOGGLE: pin_nxt = out_ff_r;
      OM_BURST_FF: pin_nxt = dcg_level & out_ff_r;
      OM_BURST_SO: pin_nxt = dcg_level & so;
      OM_BIPHASE: pin_nxt = bip_r;
      OM_MANCH: pin_nxt = so ^ half_r;
      OM_DIRECT: pin_nxt = so;
      OM_PWM: pin_nxt = out_ff_r;
      OM_NONE: pin_nxt = 1'b0;
    endcase
  end

  assign timer_out_pin = pin_r;
  assign stage_clock_out = clk_out_r;
  assign timer_irq_req = irq_r;

  // ========================================================
  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r <= CFG_RST;
      prdata_r <= 32'h0;
    end else begin
      cfg_r <= cfg_nxt;
      // unmapped reads return zero
      prdata_r <= setup ? (addr_ok ? rd_val : 32'h0) : prdata_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lo_cnt_r <= 4'h0;
      hi_cnt_r <= 8'h00;
      dcg_cnt_r <= 2'h0;
      ext_prev_r <= 1'b0;
      run_prev_r <= 1'b0;
    end else begin
      lo_cnt_r <= lo_cnt_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      dcg_cnt_r <= dcg_cnt_nxt;
      ext_prev_r <= external_count_in;
      run_prev_r <= run;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_ff_r <= 1'b0;
      armed_r <= 1'b1;
      clk_out_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      out_ff_r <= out_ff_nxt;
      armed_r <= armed_nxt;
      clk_out_r <= stage_pulse;
      irq_r <= cfg_r.im & irq_src;
    end
  end

  always_ff @(posedge clk) begin
    if (reset | ~run) begin
      half_r <= 1'b0;
      bip_r <= 1'b0;
    end else begin
      half_r <= stage_pulse ? ~half_r : half_r;
      bip_r <= bip_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

endmodule

`default_nettype wire
